// file: compare_timer.sv
// compare timer with up and continuous modes, capture channels and a vector register
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps

module compare_timer
  import tmr_pkg::*;
(
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rstn,
  input  wire logic                     system_reset,
  // count sources
  input  wire logic                     inverted_count_clock,
  input  wire logic                     subsystem_clock,
  input  wire logic                     aux_clock,
  input  wire logic                     external_count_clock,
  // capture inputs
  input  wire logic [tmr_pkg::NUM_CH-1:0] capture_in,
  // register port
  input  wire logic [tmr_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [tmr_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output      logic [tmr_pkg::DATA_W-1:0] reg_rdata,
  // interrupt
  output      logic                     irq
);

  // ----------------------------------------------------------------
  // vector encoding, used for reads and for read-to-acknowledge
  // ----------------------------------------------------------------
  function automatic logic [3:0] vec_code(input logic [STAT_W-1:0] f);
    if (f[1])
    begin
      return VEC_CH1;
    end
    else if (f[2])
    begin
      return VEC_CH2;
    end
    else if (f[STAT_OVF_BIT])
    begin
      return VEC_OVF;
    end
    return VEC_NONE;
  endfunction

  function automatic logic [STAT_W-1:0] vec_bit(input logic [STAT_W-1:0] f);
    logic [STAT_W-1:0] b;
    b = '0;
    if (f[1])
    begin
      b[1] = 1'b1;
    end
    else if (f[2])
    begin
      b[2] = 1'b1;
    end
    else if (f[STAT_OVF_BIT])
    begin
      b[STAT_OVF_BIT] = 1'b1;
    end
    return b;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0]  ctrl_q;
  logic [COUNT_W-1:0] count_value_q;
  logic [COUNT_W-1:0] cmp_q [NUM_CH];
  logic [NUM_CH-1:0]  capmode_q;
  logic [STAT_W-1:0]  flags_q;
  logic [STAT_W-1:0]  mask_q;
  logic [NUM_CH-1:0]  cap_prev_q;
  logic               src_prev_q;
  logic [DATA_W-1:0]  rdata_q;
  logic               irq_q;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic              wr_ctrl;
  logic              wr_count;
  logic              wr_capmode;
  logic              wr_status;
  logic              wr_mask;
  logic              rd_vector;
  logic [NUM_CH-1:0] wr_cmp;
  logic              clr_req;
  logic              restart;

  assign wr_ctrl    = reg_wr && (reg_addr == OFS_CTRL);
  assign wr_count   = reg_wr && (reg_addr == OFS_COUNT);
  assign wr_capmode = reg_wr && (reg_addr == OFS_CAPMODE);
  assign wr_status  = reg_wr && (reg_addr == OFS_STATUS);
  assign wr_mask    = reg_wr && (reg_addr == OFS_MASK);
  assign rd_vector  = reg_rd && (reg_addr == OFS_VECTOR);

  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      wr_cmp[i] = reg_wr &&
                  (reg_addr == ADDR_W'(OFS_CMP_BASE + ADDR_W'(i) * OFS_CMP_STEP));
    end
  end

  // clear bit is a strobe, it is never stored
  assign clr_req = wr_ctrl && reg_wdata[CTRL_CLR_BIT];
  assign restart = clr_req || system_reset;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  count_mode_e mode;
  count_src_e  src_sel;
  logic [1:0]  div_sel;
  logic        run;

  assign mode    = count_mode_e'(ctrl_q[CTRL_MODE_LSB +: 2]);
  assign src_sel = count_src_e'(ctrl_q[CTRL_SRC_LSB +: 2]);
  assign div_sel = ctrl_q[CTRL_DIV_LSB +: 2];
  assign run     = (mode == MODE_UP) || (mode == MODE_CONT);

  // ----------------------------------------------------------------
  // source select and edge detect
  // ----------------------------------------------------------------
  logic src_lvl;
  logic tick;
  logic inc;

  always_comb
  begin
    unique case (src_sel)
      SRC_EXT: src_lvl = external_count_clock;
      SRC_AUX: src_lvl = aux_clock;
      SRC_SUB: src_lvl = subsystem_clock;
      SRC_INV: src_lvl = inverted_count_clock;
    endcase
  end

  assign tick = src_lvl && !src_prev_q;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      src_prev_q <= 1'b0;
    end
    else
    begin
      src_prev_q <= src_lvl;
    end
  end

  count_prescaler u_prescaler (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .restart (restart),
    .run     (run),
    .div_sel (div_sel),
    .tick    (tick),
    .inc     (inc)
  );

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  logic               at_period;
  logic               wrap_ovf;
  logic [COUNT_W-1:0] count_nxt;

  // overflow comes only from a real wrap, so a cleared counter restarting
  // at zero cannot raise it on its first edge unless the channel 0 period is zero
  assign at_period = (mode == MODE_UP) && (count_value_q == cmp_q[0]);
  assign wrap_ovf  = inc && (at_period ||
                     ((mode == MODE_CONT) && (count_value_q == '1)));
  assign count_nxt = at_period ? COUNT_RST : count_value_q + COUNT_W'(1);

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      count_value_q <= COUNT_RST;
    end
    else if (restart)
    begin
      count_value_q <= COUNT_RST;
    end
    else if (wr_count)
    begin
      count_value_q <= reg_wdata[COUNT_W-1:0];
    end
    else if (inc)
    begin
      count_value_q <= count_nxt;
    end
  end

  // ----------------------------------------------------------------
  // control, capture mode and mask
  // ----------------------------------------------------------------
  // compare writes have no path into control, so a system reset leaves it clean
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_q <= CTRL_RST;
    end
    else if (system_reset)
    begin
      ctrl_q <= CTRL_RST;
    end
    else if (wr_ctrl)
    begin
      ctrl_q <= reg_wdata[CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      capmode_q <= '0;
      mask_q    <= '0;
    end
    else if (system_reset)
    begin
      capmode_q <= '0;
      mask_q    <= '0;
    end
    else
    begin
      if (wr_capmode)
      begin
        capmode_q <= reg_wdata[NUM_CH-1:0];
      end
      if (wr_mask)
      begin
        mask_q <= reg_wdata[STAT_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // compare values and capture
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] cap_edge;
  logic [NUM_CH-1:0] cmp_hit;

  assign cap_edge = capture_in & ~cap_prev_q;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      cap_prev_q <= '0;
    end
    else
    begin
      cap_prev_q <= capture_in;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        cmp_q[i] <= CMP_RST;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        if (wr_cmp[i])
        begin
          cmp_q[i] <= reg_wdata[COUNT_W-1:0];
        end
        else if (capmode_q[i] && cap_edge[i])
        begin
          cmp_q[i] <= count_value_q;
        end
      end
    end
  end

  // match uses the live compare value against the count being entered, so a
  // value raised just before an increment is seen on that very increment
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      cmp_hit[i] = inc && !capmode_q[i] && (count_nxt == cmp_q[i]);
    end
  end

  // ----------------------------------------------------------------
  // flags, vector and interrupt
  // ----------------------------------------------------------------
  logic [STAT_W-1:0] flag_set;
  logic [STAT_W-1:0] flag_clr;

  always_comb
  begin
    flag_set               = '0;
    flag_set[NUM_CH-1:0]   = cmp_hit | (capmode_q & cap_edge);
    flag_set[STAT_OVF_BIT] = wrap_ovf;
    flag_clr               = '0;
    if (wr_status)
    begin
      flag_clr = reg_wdata[STAT_W-1:0];
    end
    if (wr_ctrl)
    begin
      // full control write empties the vector sources
      flag_clr = flag_clr | vec_bit('1) | ({STAT_W{1'b1}} & ~STAT_W'(1));
    end
    if (rd_vector)
    begin
      flag_clr = flag_clr | vec_bit(flags_q);
    end
  end

  // set wins over a status, control or vector-read clear in the same cycle; system reset wins over set
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      flags_q <= STAT_RST;
    end
    else if (system_reset)
    begin
      flags_q <= STAT_RST;
    end
    else
    begin
      flags_q <= (flags_q & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(flags_q & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rd_mux;

  always_comb
  begin
    rd_mux = '0;
    unique case (reg_addr)
      OFS_CTRL:    rd_mux[CTRL_W-1:0]  = ctrl_q;
      OFS_COUNT:   rd_mux[COUNT_W-1:0] = count_value_q;
      OFS_VECTOR:  rd_mux[3:0]         = vec_code(flags_q);
      OFS_CAPMODE: rd_mux[NUM_CH-1:0]  = capmode_q;
      OFS_STATUS:  rd_mux[STAT_W-1:0]  = flags_q;
      OFS_MASK:    rd_mux[STAT_W-1:0]  = mask_q;
      default:
      begin
        for (int i = 0; i < NUM_CH; i++)
        begin
          if (reg_addr == ADDR_W'(OFS_CMP_BASE + ADDR_W'(i) * OFS_CMP_STEP))
          begin
            rd_mux[COUNT_W-1:0] = cmp_q[i];
          end
        end
      end
    endcase
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata_q <= '0;
    end
    else if (reg_rd)
    begin
      rdata_q <= rd_mux;
    end
    else
    begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq       = irq_q;

endmodule

// file: compare_timer_monitor.sv
// assertion checker for the compare timer, bound to its ports
`timescale 1ns/1ps

module compare_timer_monitor
  import tmr_pkg::*;
(
  // clock and resets
  input wire logic                       clk_sys,
  input wire logic                       rstn,
  input wire logic                       system_reset,
  // count sources and captures
  input wire logic                       inverted_count_clock,
  input wire logic                       subsystem_clock,
  input wire logic                       aux_clock,
  input wire logic                       external_count_clock,
  input wire logic [tmr_pkg::NUM_CH-1:0] capture_in,
  // register port
  input wire logic [tmr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [tmr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [tmr_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                       irq
);
  logic [tmr_pkg::NUM_CH+3:0] ev;
  logic [tmr_pkg::NUM_CH+3:0] ev1_q;
  logic [tmr_pkg::NUM_CH+3:0] ev2_q;
  logic                       quiet;
  logic                       stop_wr;

  // no edge in flight, so a write never races an increment or capture
  assign ev = {capture_in, inverted_count_clock, subsystem_clock, aux_clock, external_count_clock};
  assign quiet = (ev == ev1_q) && (ev1_q == ev2_q);
  assign stop_wr = reg_wr && reg_addr == OFS_CTRL && quiet
                   && reg_wdata[CTRL_MODE_LSB +: 2] == MODE_STOP;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ev1_q <= '0;
      ev2_q <= '0;
    end
    else
    begin
      ev1_q <= ev;
      ev2_q <= ev1_q;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  property p_read_idle;
    !reg_rd |=> reg_rdata == '0;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data outside a read");

  property p_hole_read;
    reg_rd && reg_addr == 8'h18 |=> reg_rdata == '0;
  endproperty
  a_hole_read: assert property (p_hole_read) else $error("unmapped read not zero");

  property p_mask_off;
    reg_wr && reg_addr == OFS_MASK && reg_wdata[3:0] == 4'h0
    ##1 !(reg_wr && reg_addr == OFS_MASK) |=> !irq;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq with mask cleared");

  property p_sys_irq;
    system_reset |-> ##2 !irq;
  endproperty
  a_sys_irq: assert property (p_sys_irq) else $error("irq after watchdog reset");

  property p_clear_zero;
    stop_wr && reg_wdata[CTRL_CLR_BIT] ##2 reg_rd && reg_addr == OFS_COUNT |=> reg_rdata == '0;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("count not zero after clear");

  property p_ctrl_vec;
    stop_wr ##2 reg_rd && reg_addr == OFS_VECTOR |=> reg_rdata == '0;
  endproperty
  a_ctrl_vec: assert property (p_ctrl_vec) else $error("vector kept after control write");

  property p_sys_ctrl;
    system_reset ##1 reg_wr && reg_addr == OFS_CMP_BASE
    ##2 reg_rd && reg_addr == OFS_CTRL |=> reg_rdata == '0;
  endproperty
  a_sys_ctrl: assert property (p_sys_ctrl) else $error("control altered after reset");

  property p_count_wr;
    reg_wr && reg_addr == OFS_COUNT && quiet ##2 reg_rd && reg_addr == OFS_COUNT
    |=> reg_rdata == {16'h0, $past(reg_wdata[15:0], 3)};
  endproperty
  a_count_wr: assert property (p_count_wr) else $error("count write lost");
endmodule

bind compare_timer compare_timer_monitor u_mon
(
  .clk_sys, .rstn, .system_reset, .inverted_count_clock, .subsystem_clock, .aux_clock,
  .external_count_clock, .capture_in, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .irq
);

// file: compare_timer_tb.sv
// self-checking testbench for the compare timer
`timescale 1ns/1ps

module compare_timer_tb;
  import tmr_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CMP1 = OFS_CMP_BASE + OFS_CMP_STEP;
  localparam logic [ADDR_W-1:0] CMP2 = CMP1 + OFS_CMP_STEP;
  logic              clk_sys;
  logic              rstn;
  logic              system_reset;
  logic [3:0]        src_v;
  logic [NUM_CH-1:0] capture_in;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic              irq;
  int                failures;
  int                n_tests;

  compare_timer uut
  (
    .clk_sys, .rstn, .system_reset, .capture_in, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .irq,
    .external_count_clock (src_v[0]),
    .aux_clock            (src_v[1]),
    .subsystem_clock      (src_v[2]),
    .inverted_count_clock (src_v[3])
  );

  always #50 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // strobe dropped one edge before the next access, so no signal is driven twice at once
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                     input logic [31:0] m = 32'hffffffff);
    logic [31:0] d;
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    chk(d & m, exp);
    @(posedge clk_sys);
  endtask

  task automatic chk_irq(input logic exp);
    #1 chk({31'h0, irq}, {31'h0, exp});
    @(posedge clk_sys);
  endtask

  // one rising edge of a count source, slow against the system clock
  task automatic tick(input int i);
    src_v[i] <= 1'b1;
    repeat (2) @(posedge clk_sys);
    src_v[i] <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  function automatic logic [31:0] ctl(input logic c, input logic [1:0] dv,
                                      input logic [1:0] md, input logic [1:0] sc);
    return {25'h0, c, dv, md, sc};
  endfunction

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    report_and_stop;
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    rstn = 1'b0;
    system_reset = 1'b0;
    src_v = 4'h0;
    capture_in = '0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    failures = 0;
    n_tests = 0;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rdc(OFS_CTRL, 32'h0);
    rdc(OFS_COUNT, 32'h0);
    rdc(OFS_STATUS, 32'h0);
    rdc(OFS_VECTOR, 32'h0);
    rdc(OFS_CMP_BASE, 32'h0);
    wr(8'h18, 32'hffffffff);
    rdc(8'h18, 32'h0);
    wr(OFS_MASK, 32'hffffffff);
    rdc(OFS_MASK, 32'hf);
    wr(OFS_CAPMODE, 32'hffffffff);
    rdc(OFS_CAPMODE, 32'h7);
    wr(OFS_CAPMODE, 32'h0);
    wr(OFS_CTRL, 32'h7f);
    rdc(OFS_CTRL, 32'h3f);
    $display("done: registers");
    wr(OFS_CMP_BASE, 32'hffff);
    for (int s = 0; s < 4; s++)
    begin
      wr(OFS_CTRL, ctl(1'b1, 2'(s), MODE_UP, 2'(s)));
      tick((s + 1) % 4);
      rdc(OFS_COUNT, 32'h0);
      tick(s);
      rdc(OFS_COUNT, 32'h1);
      repeat ((1 << s) - 1) tick(s);
      rdc(OFS_COUNT, 32'h1);
      tick(s);
      rdc(OFS_COUNT, 32'h2);
    end
    $display("done: sources and divider");
    // channels 1 and 2 at zero would hit on every wrap and hide the overflow code
    wr(CMP1, 32'h3);
    wr(CMP2, 32'h5);
    wr(OFS_CMP_BASE, 32'h2);
    wr(OFS_MASK, 32'h8);
    wr(OFS_CTRL, ctl(1'b1, 2'b00, MODE_UP, SRC_EXT));
    repeat (2) tick(0);
    rdc(OFS_COUNT, 32'h2);
    rdc(OFS_STATUS, 32'h0, 32'h8);
    chk_irq(1'b0);
    tick(0);
    rdc(OFS_COUNT, 32'h0);
    rdc(OFS_STATUS, 32'h8, 32'h8);
    chk_irq(1'b1);
    rdc(OFS_VECTOR, 32'ha);
    repeat (2) tick(0);
    wr(OFS_CTRL, ctl(1'b0, 2'b00, MODE_STOP, SRC_EXT));
    wr(OFS_CTRL, ctl(1'b1, 2'b00, MODE_UP, SRC_EXT));
    tick(0);
    rdc(OFS_COUNT, 32'h1);
    rdc(OFS_STATUS, 32'h0, 32'h8);
    $display("done: up mode");
    wr(CMP1, 32'h3);
    wr(CMP2, 32'h5);
    wr(OFS_MASK, 32'h6);
    wr(OFS_CTRL, ctl(1'b1, 2'b00, MODE_CONT, SRC_EXT));
    repeat (3) tick(0);
    rdc(OFS_STATUS, 32'h2, 32'h6);
    chk_irq(1'b1);
    rdc(OFS_VECTOR, 32'h2);
    wr(CMP1, 32'h4);
    tick(0);
    rdc(OFS_VECTOR, 32'h2);
    wr(OFS_CAPMODE, 32'h2);
    wr(CMP1, 32'h5);
    wr(OFS_CAPMODE, 32'h0);
    tick(0);
    rdc(OFS_VECTOR, 32'h2);
    rdc(OFS_VECTOR, 32'h4);
    rdc(OFS_VECTOR, 32'h0);
    chk_irq(1'b0);
    wr(OFS_CAPMODE, 32'h2);
    capture_in <= 3'b010;
    repeat (2) @(posedge clk_sys);
    capture_in <= '0;
    repeat (2) @(posedge clk_sys);
    rdc(CMP1, 32'h5);
    rdc(OFS_VECTOR, 32'h2);
    wr(OFS_CAPMODE, 32'h0);
    $display("done: compare");
    wr(OFS_COUNT, 32'h1234);
    rdc(OFS_COUNT, 32'h1234);
    wr(OFS_CTRL, ctl(1'b1, 2'b00, MODE_STOP, SRC_EXT));
    rdc(OFS_COUNT, 32'h0);
    wr(OFS_MASK, 32'h0);
    wr(OFS_CTRL, ctl(1'b1, 2'b00, MODE_UP, SRC_EXT));
    repeat (3) tick(0);
    rdc(OFS_STATUS, 32'h8, 32'h8);
    chk_irq(1'b0);
    wr(OFS_MASK, 32'h8);
    rdc(OFS_STATUS, 32'h8, 32'h8);
    chk_irq(1'b1);
    wr(OFS_STATUS, 32'h8);
    rdc(OFS_STATUS, 32'h0, 32'h8);
    chk_irq(1'b0);
    repeat (3) tick(0);
    wr(OFS_CTRL, 32'h0);
    rdc(OFS_VECTOR, 32'h0);
    chk_irq(1'b0);
    wr(OFS_CTRL, ctl(1'b0, 2'b01, MODE_UP, SRC_AUX));
    system_reset <= 1'b1;
    @(posedge clk_sys);
    system_reset <= 1'b0;
    wr(OFS_CMP_BASE, 32'h3);
    rdc(OFS_CTRL, 32'h0);
    rdc(OFS_VECTOR, 32'h0);
    rdc(OFS_CMP_BASE, 32'h3);
    wr(OFS_MASK, 32'h8);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rdc(OFS_MASK, 32'h0);
    $display("done: resets and vector");
    report_and_stop;
  end
endmodule

// file: count_prescaler.sv
// input divider that lets the first tick after a restart through undivided
`timescale 1ns/1ps

module count_prescaler
  import tmr_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  // control
  input  wire logic                 restart,
  input  wire logic                 run,
  input  wire logic [1:0]           div_sel,
  // source edge in, increment out
  input  wire logic                 tick,
  output      logic                 inc
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic                 first_q;
  logic [DIV_CNT_W-1:0] cnt_q;
  logic [DIV_CNT_W-1:0] limit;

  assign limit = DIV_CNT_W'((1 << div_sel) - 1);
  // first edge after restart counts at once, later ones are divided
  assign inc   = run && tick && (first_q || (cnt_q == limit));

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      first_q <= 1'b1;
    end
    else if (restart)
    begin
      first_q <= 1'b1;
    end
    else if (inc)
    begin
      first_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_q <= '0;
    end
    else if (restart || inc)
    begin
      cnt_q <= '0;
    end
    else if (run && tick)
    begin
      cnt_q <= cnt_q + DIV_CNT_W'(1);
    end
  end

endmodule

// file: tmr_pkg.sv
// shared constants for the compare timer: register map, field layout, reset values
package tmr_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned COUNT_W   = 16;
  localparam int unsigned NUM_CH    = 3;
  localparam int unsigned DIV_CNT_W = 3;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_COUNT    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_VECTOR   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CAPMODE  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_MASK     = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CMP_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CMP_STEP = 8'h04;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_SRC_LSB  = 0;
  localparam int unsigned CTRL_MODE_LSB = 2;
  localparam int unsigned CTRL_DIV_LSB  = 4;
  localparam int unsigned CTRL_CLR_BIT  = 6;
  localparam int unsigned CTRL_W        = 6;

  // ----------------------------------------------------------------
  // status bits: one per channel, then overflow
  // ----------------------------------------------------------------
  localparam int unsigned STAT_OVF_BIT = NUM_CH;
  localparam int unsigned STAT_W       = NUM_CH + 1;

  // ----------------------------------------------------------------
  // vector codes
  // ----------------------------------------------------------------
  localparam logic [3:0] VEC_NONE = 4'h0;
  localparam logic [3:0] VEC_CH1  = 4'h2;
  localparam logic [3:0] VEC_CH2  = 4'h4;
  localparam logic [3:0] VEC_OVF  = 4'ha;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [CTRL_W-1:0]  CTRL_RST  = 6'h00;
  localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [COUNT_W-1:0] CMP_RST   = 16'h0000;
  localparam logic [STAT_W-1:0]  STAT_RST  = 4'h0;

  // ----------------------------------------------------------------
  // count modes and clock sources
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_STOP = 2'b00,
    MODE_UP   = 2'b01,
    MODE_CONT = 2'b10,
    MODE_RSVD = 2'b11
  } count_mode_e;

  typedef enum logic [1:0] {
    SRC_EXT = 2'b00,
    SRC_AUX = 2'b01,
    SRC_SUB = 2'b10,
    SRC_INV = 2'b11
  } count_src_e;

endpackage
